//--- hdl/uart_mp_pkg.sv
// Overview of operation
// - Voted stop bit zero flags frame fault
// - Rearm start detection after last stop vote
// - Sixteen samples per bit, eight double speed
// - First vote sample 8, or 4
// - Middle vote sample 9, or 5
// - Character plus parity spans 5 to 10
// - Normal speed baud error about two percent
// - Double speed error 1.5 or 1.0 percent
// - Filter drops non-address frames before buffer
// - Filter leaves transmitter untouched
// - Type from first stop, or ninth bit
// - Type one address, zero data
// - Address frame stored and flagged as usual
// - Filter enable shares word with transmit-done flag
// - One character size for both directions
// - Bit level by majority of three
// - Frame and parity error flags buffered with their frame
package uart_mp_pkg;
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_CSA = 3'h1;
   localparam logic [2:0] ADDR_CSB = 3'h2;
   localparam logic [2:0] ADDR_CSC = 3'h3;
   localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
   localparam logic [2:0] ADDR_BAUD_HI = 3'h5;
   localparam int A_RXC = 7;
   localparam int A_TXC = 6;
   localparam int A_U2X = 1;
   localparam int A_MPCM = 0;
   localparam int B_RXEN = 4;
   localparam int B_TXEN = 3;
   localparam int B_SZ2 = 2;
   localparam int B_TB8 = 0;
   localparam int C_PAR_EN = 5;
   localparam int C_PAR_ODD = 4;
   localparam int C_STOP2 = 3;
   localparam int C_SZ_LO = 1;
   localparam logic [1:0] SZ_LO_RST = 2'h3;
   localparam logic [11:0] BAUD_RST = 12'h000;
   localparam logic [2:0] CHAR9_CODE = 3'h7;
   localparam logic [4:0] SPB_NORM = 5'h10;
   localparam logic [4:0] SPB_DBL = 5'h08;
   localparam logic [4:0] SF_NORM = 5'h08;
   localparam logic [4:0] SF_DBL = 5'h04;
   localparam logic [4:0] SM_NORM = 5'h09;
   localparam logic [4:0] SM_DBL = 5'h05;
   localparam logic [3:0] MIN_DATA_BITS = 4'h5;
   localparam int FIFO_DEPTH = 2;

   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } rx_state_type;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_BUSY = 2'b10
   } tx_state_type;
endpackage

//--- hdl/uart_mp_filter.sv
`timescale 1ns/1ps
module uart_mp_filter (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_rxd,
   output logic o_txd
);
   localparam int FIFO_DEPTH = uart_mp_pkg::FIFO_DEPTH;
   logic rxd_meta_q, rxd_q;
   logic [11:0] baud_q, baud_cnt_q;
   logic tick;
   logic u2x_q, mpcm_q, rxen_q, txen_q, sz2_q, tb8_q, par_en_q, par_odd_q, stop2_q;
   logic [1:0] sz_lo_q;
   logic [2:0] sz;
   logic nine;
   logic [3:0] data_bits, frame_bits;
   logic [8:0] mask9;
   logic [4:0] spb, sf, sm, sl;
   uart_mp_pkg::rx_state_type rx_state_q;
   logic [4:0] cnt_q;
   logic [3:0] bit_idx_q;
   logic v0_q, v1_q, vote;
   logic [9:0] shift_q;
   logic frame_done;
   logic [8:0] rx_char;
   logic rx_par, rx_pe, rx_fe, ftype, accept;
   logic [10:0] mem_q [FIFO_DEPTH];
   logic wr_ptr_q, rd_ptr_q;
   logic [1:0] count_q;
   logic pop, push, blocked, dor_q;
   logic [10:0] head;
   logic wr_csa;
   logic txc_q, tx_full_q, tx_b8_q, tx_done;
   logic [7:0] tx_buf_q;
   uart_mp_pkg::tx_state_type tx_state_q;
   logic [12:0] tx_frame, tx_shift_q;
   logic [3:0] tx_bits_q;
   logic [4:0] tx_cnt_q;
   logic txd_q;
   logic [7:0] rdata_q;

   // Pin passes two flops before any logic sees it
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rxd_meta_q <= 1'b1;
         rxd_q <= 1'b1;
      end else begin
         rxd_meta_q <= i_rxd;
         rxd_q <= rxd_meta_q;
      end
   end

   // Sample tick; divisor choice sets baud error budget
   assign tick = (baud_cnt_q == 12'h000);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         baud_cnt_q <= uart_mp_pkg::BAUD_RST;
      end else if (tick) begin
         baud_cnt_q <= baud_q;
      end else begin
         baud_cnt_q <= baud_cnt_q - 12'h001;
      end
   end

   // Shared character size for receiver and transmitter
   assign sz = {sz2_q, sz_lo_q};
   assign nine = (sz == uart_mp_pkg::CHAR9_CODE);
   always_comb begin
      if (sz[2] == 1'b0) begin
         data_bits = uart_mp_pkg::MIN_DATA_BITS + {2'h0, sz[1:0]};
      end else if (nine) begin
         data_bits = 4'h9;
      end else begin
         data_bits = 4'h8;
      end
   end
   assign frame_bits = data_bits + {3'h0, par_en_q};
   assign mask9 = 9'h1FF >> (4'h9 - data_bits);

   assign spb = u2x_q ? uart_mp_pkg::SPB_DBL : uart_mp_pkg::SPB_NORM;
   assign sf = u2x_q ? uart_mp_pkg::SF_DBL : uart_mp_pkg::SF_NORM;
   assign sm = u2x_q ? uart_mp_pkg::SM_DBL : uart_mp_pkg::SM_NORM;
   assign sl = sm + 5'h01;

   assign vote = (v0_q & v1_q) | (v0_q & rxd_q) | (v1_q & rxd_q);
   assign frame_done = (rx_state_q == uart_mp_pkg::RX_STOP) && tick && (cnt_q == sl);

   // Receive sequencer; disabling drops the frame in progress
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !rxen_q) begin
         rx_state_q <= uart_mp_pkg::RX_IDLE;
         cnt_q <= 5'h00;
         bit_idx_q <= 4'h0;
      end else if (tick) begin
         unique case (rx_state_q)
            uart_mp_pkg::RX_IDLE: begin
               if (!rxd_q) begin
                  rx_state_q <= uart_mp_pkg::RX_START;
                  cnt_q <= 5'h02;
               end
            end
            uart_mp_pkg::RX_START: begin
               cnt_q <= (cnt_q == spb) ? 5'h01 : cnt_q + 5'h01;
               if (cnt_q == sl && vote) begin
                  rx_state_q <= uart_mp_pkg::RX_IDLE;
               end else if (cnt_q == spb) begin
                  rx_state_q <= uart_mp_pkg::RX_DATA;
                  bit_idx_q <= 4'h0;
               end
            end
            uart_mp_pkg::RX_DATA: begin
               cnt_q <= (cnt_q == spb) ? 5'h01 : cnt_q + 5'h01;
               if (cnt_q == spb) begin
                  if (bit_idx_q == frame_bits - 4'h1) begin
                     rx_state_q <= uart_mp_pkg::RX_STOP;
                  end else begin
                     bit_idx_q <= bit_idx_q + 4'h1;
                  end
               end
            end
            uart_mp_pkg::RX_STOP: begin
               cnt_q <= cnt_q + 5'h01;
               // Rearm right after the last vote, no full stop bit
               if (cnt_q == sl) begin
                  rx_state_q <= uart_mp_pkg::RX_IDLE;
               end
            end
         endcase
      end
   end

   // Vote samples and bit capture
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         v0_q <= 1'b1;
         v1_q <= 1'b1;
         shift_q <= 10'h000;
      end else if (tick) begin
         if (cnt_q == sf) begin
            v0_q <= rxd_q;
         end
         if (cnt_q == sm) begin
            v1_q <= rxd_q;
         end
         if (rx_state_q == uart_mp_pkg::RX_START) begin
            shift_q <= 10'h000;
         end else if (rx_state_q == uart_mp_pkg::RX_DATA && cnt_q == sl) begin
            shift_q[bit_idx_q] <= vote;
         end
      end
   end

   assign rx_char = shift_q[8:0] & mask9;
   assign rx_par = shift_q[data_bits];
   assign rx_pe = par_en_q & (^rx_char ^ rx_par ^ par_odd_q);
   assign rx_fe = ~vote;
   assign ftype = nine ? rx_char[8] : vote;
   assign accept = frame_done && !(mpcm_q && !ftype);

   // Two-entry receive buffer, flags kept per frame
   assign pop = i_rd && (i_addr == uart_mp_pkg::ADDR_DATA) && (count_q != 2'h0);
   assign blocked = (count_q == 2'h2) && !pop;
   assign push = accept && !blocked;
   assign head = (count_q != 2'h0) ? mem_q[rd_ptr_q] : 11'h000;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            mem_q[i] <= 11'h000;
         end
      end else if (push) begin
         mem_q[wr_ptr_q] <= {rx_pe, rx_fe, rx_char};
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !rxen_q) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         count_q <= count_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // Lost-frame marker holds until a frame is stored again
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !rxen_q) begin
         dor_q <= 1'b0;
      end else if (accept && blocked) begin
         dor_q <= 1'b1;
      end else if (push) begin
         dor_q <= 1'b0;
      end
   end

   // Control registers
   assign wr_csa = i_wr && (i_addr == uart_mp_pkg::ADDR_CSA);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         u2x_q <= 1'b0;
         mpcm_q <= 1'b0;
         rxen_q <= 1'b0;
         txen_q <= 1'b0;
         sz2_q <= 1'b0;
         tb8_q <= 1'b0;
         par_en_q <= 1'b0;
         par_odd_q <= 1'b0;
         stop2_q <= 1'b0;
         sz_lo_q <= uart_mp_pkg::SZ_LO_RST;
         baud_q <= uart_mp_pkg::BAUD_RST;
      end else if (i_wr) begin
         unique case (i_addr)
            uart_mp_pkg::ADDR_CSA: begin
               u2x_q <= i_wdata[uart_mp_pkg::A_U2X];
               mpcm_q <= i_wdata[uart_mp_pkg::A_MPCM];
            end
            uart_mp_pkg::ADDR_CSB: begin
               rxen_q <= i_wdata[uart_mp_pkg::B_RXEN];
               txen_q <= i_wdata[uart_mp_pkg::B_TXEN];
               sz2_q <= i_wdata[uart_mp_pkg::B_SZ2];
               tb8_q <= i_wdata[uart_mp_pkg::B_TB8];
            end
            uart_mp_pkg::ADDR_CSC: begin
               par_en_q <= i_wdata[uart_mp_pkg::C_PAR_EN];
               par_odd_q <= i_wdata[uart_mp_pkg::C_PAR_ODD];
               stop2_q <= i_wdata[uart_mp_pkg::C_STOP2];
               sz_lo_q <= i_wdata[uart_mp_pkg::C_SZ_LO +: 2];
            end
            uart_mp_pkg::ADDR_BAUD_LO: baud_q[7:0] <= i_wdata;
            uart_mp_pkg::ADDR_BAUD_HI: baud_q[11:8] <= i_wdata[3:0];
            default: ;
         endcase
      end
   end

   // Transmit-done: one-to-clear, shares the word with the filter enable
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         txc_q <= 1'b0;
      end else if (tx_done) begin
         txc_q <= 1'b1;
      end else if (wr_csa && i_wdata[uart_mp_pkg::A_TXC]) begin
         txc_q <= 1'b0;
      end
   end

   // Transmitter ignores the filter setting entirely
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tx_full_q <= 1'b0;
         tx_buf_q <= 8'h00;
         tx_b8_q <= 1'b0;
      end else if (i_wr && i_addr == uart_mp_pkg::ADDR_DATA && !tx_full_q) begin
         tx_full_q <= 1'b1;
         tx_buf_q <= i_wdata;
         tx_b8_q <= tb8_q;
      end else if (tx_state_q == uart_mp_pkg::TX_IDLE && txen_q) begin
         tx_full_q <= 1'b0;
      end
   end

   always_comb begin
      logic [8:0] d9;
      d9 = {tx_b8_q, tx_buf_q} & mask9;
      tx_frame = {3'h7, d9 | ~mask9, 1'b0};
      if (par_en_q) begin
         tx_frame[data_bits + 4'h1] = ^d9 ^ par_odd_q;
      end
   end

   assign tx_done = (tx_state_q == uart_mp_pkg::TX_BUSY) && tick && (tx_cnt_q == spb - 5'h01)
                    && (tx_bits_q == 4'h0) && !tx_full_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tx_state_q <= uart_mp_pkg::TX_IDLE;
         tx_shift_q <= 13'h1FFF;
         tx_bits_q <= 4'h0;
         tx_cnt_q <= 5'h00;
         txd_q <= 1'b1;
      end else begin
         unique case (tx_state_q)
            uart_mp_pkg::TX_IDLE: begin
               txd_q <= 1'b1;
               if (tx_full_q && txen_q) begin
                  tx_state_q <= uart_mp_pkg::TX_BUSY;
                  tx_shift_q <= tx_frame;
                  tx_bits_q <= frame_bits + {3'h0, stop2_q} + 4'h1;
                  tx_cnt_q <= 5'h00;
               end
            end
            uart_mp_pkg::TX_BUSY: begin
               txd_q <= tx_shift_q[0];
               if (tick) begin
                  if (tx_cnt_q == spb - 5'h01) begin
                     tx_cnt_q <= 5'h00;
                     tx_shift_q <= {1'b1, tx_shift_q[12:1]};
                     if (tx_bits_q == 4'h0) begin
                        tx_state_q <= uart_mp_pkg::TX_IDLE;
                     end else begin
                        tx_bits_q <= tx_bits_q - 4'h1;
                     end
                  end else begin
                     tx_cnt_q <= tx_cnt_q + 5'h01;
                  end
               end
            end
         endcase
      end
   end
   assign o_txd = txd_q;

   // Read data stands one cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rdata_q <= 8'h00;
      end else if (i_rd) begin
         unique case (i_addr)
            uart_mp_pkg::ADDR_DATA: rdata_q <= head[7:0];
            uart_mp_pkg::ADDR_CSA: rdata_q <= {count_q != 2'h0, txc_q, !tx_full_q, head[9],
                                              dor_q, head[10], u2x_q, mpcm_q};
            uart_mp_pkg::ADDR_CSB: rdata_q <= {3'h0, rxen_q, txen_q, sz2_q, head[8], tb8_q};
            uart_mp_pkg::ADDR_CSC: rdata_q <= {2'h0, par_en_q, par_odd_q, stop2_q, sz_lo_q, 1'b0};
            uart_mp_pkg::ADDR_BAUD_LO: rdata_q <= baud_q[7:0];
            uart_mp_pkg::ADDR_BAUD_HI: rdata_q <= {4'h0, baud_q[11:8]};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign o_rdata = rdata_q;

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_stop_fault_stored: assert property (push |=> mem_q[$past(wr_ptr_q)][9] == !$past(vote))
      else $error("stop fault not stored with frame");
   a_early_rearm: assert property (frame_done |=> rx_state_q == uart_mp_pkg::RX_IDLE)
      else $error("receiver not idle after stop vote");
   a_sample_wrap: assert property ((rx_state_q inside {uart_mp_pkg::RX_START, uart_mp_pkg::RX_DATA}) && tick && cnt_q == spb && rxen_q |=> cnt_q == 5'h01 || !rxen_q)
      else $error("sample counter did not wrap at bit end");
   a_first_sample: assert property (tick && cnt_q == sf && rx_state_q != uart_mp_pkg::RX_IDLE |=> v0_q == $past(rxd_q))
      else $error("first vote sample wrong");
   a_mid_sample: assert property (tick && cnt_q == sm && rx_state_q != uart_mp_pkg::RX_IDLE |=> v1_q == $past(rxd_q))
      else $error("middle vote sample wrong");
   a_frame_length: assert property (rx_state_q == uart_mp_pkg::RX_DATA |-> bit_idx_q < frame_bits)
      else $error("bit index beyond frame length");
   a_filter_drop: assert property (frame_done && mpcm_q && !ftype |=> count_q <= $past(count_q))
      else $error("data frame entered buffer while filtering");
   a_addr_kept: assert property (frame_done && ftype && count_q == 2'h0 |=> count_q == 2'h1)
      else $error("address frame not stored");
   a_txc_set_wins: assert property (tx_done |=> txc_q)
      else $error("transmit done flag lost");
   a_majority_bit: assert property (rx_state_q == uart_mp_pkg::RX_DATA && tick && cnt_q == sl |=> shift_q[$past(bit_idx_q)] == $past(vote))
      else $error("data bit not majority");

   c_addr_frame: cover property (frame_done && mpcm_q && ftype);
   c_dropped_frame: cover property (frame_done && mpcm_q && !ftype);
   c_frame_fault: cover property (push && rx_fe);
   c_double_speed: cover property (frame_done && u2x_q);
endmodule

//--- verification/serial_far_end.sv
`timescale 1ns/1ps
module serial_far_end (
   input wire logic i_clk,
   input wire logic i_txd,
   output logic o_rxd
);
   int bclk = 16;

   initial o_rxd = 1'b1;

   // Exact bit length, so the far end adds no rate error
   task automatic put(input logic v, input int n, input int gl);
      for (int c = 0; c < n; c++) begin
         @(posedge i_clk);
         o_rxd <= (c == gl) ? ~v : v;
      end
   endtask

   // Ninth bit or first stop carries the frame type
   task automatic send(input int nb, input int d, input int par, input int st, input int gb);
      put(1'b0, bclk, -1);
      for (int i = 0; i < nb; i++) begin
         put(d[i], bclk, (i == gb) ? bclk / 2 + 1 : -1);
      end
      if (par >= 0) begin
         put(par[0], bclk, -1);
      end
      put(st[0], bclk * 3 / 4, -1);
      // A zero type stop still needs a real stop behind it
      if (st == 0) begin
         put(1'b1, bclk, -1);
      end
   endtask

   task automatic catch(input int nb, output logic [8:0] d, output logic ok);
      int w;
      d = 9'h000;
      w = 0;
      while (i_txd !== 1'b0 && w < 4000) begin
         @(posedge i_clk);
         w++;
      end
      repeat (bclk / 2) @(posedge i_clk);
      for (int i = 0; i < nb; i++) begin
         repeat (bclk) @(posedge i_clk);
         d[i] = i_txd;
      end
      repeat (bclk) @(posedge i_clk);
      ok = (w < 4000) && (i_txd === 1'b1);
   endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] o_rdata;
   logic o_txd;
   logic rxd;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int nb = 8;
   int pen = 0;
   int odd = 0;
   int filt = 0;
   int ovr = 0;
   int q[$];
   int e;
   int d;
   int codes[5] = '{0, 1, 2, 3, 7};
   logic [7:0] rst_v [1:7] = '{8'h20, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] rv;
   logic [8:0] tv;
   logic tok;

   always #5 i_clk = ~i_clk;

   uart_mp_filter u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(rxd),
      .o_txd(o_txd));
   serial_far_end u_far (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(rxd));

   task automatic summarize();
      if (err_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask

   task automatic cfg(input int code, input int p, input int o, input int dbl, input int f);
      nb = (code == 7) ? 9 : code + 5;
      pen = p;
      odd = o;
      filt = f;
      u_far.bclk = dbl ? 8 : 16;
      wr(3'h3, 8'((p << 5) | (o << 4) | ((code & 3) << 1)));
      wr(3'h2, 8'(8'h18 | (code & 4)));
      // Whole-byte write, never a patch of the shared word
      wr(3'h1, 8'((dbl << 1) | f));
   endtask

   task automatic frame(input int dv, input int st, input int bp, input int gb);
      int m;
      int pv;
      int typ;
      m = dv & ((1 << nb) - 1);
      pv = pen ? ((^m) ^ odd ^ bp) : -1;
      typ = (nb == 9) ? m[8] : st;
      if (!(filt && typ == 0)) begin
         // Full two-entry buffer loses the frame and marks overrun
         if (q.size() == 2) begin
            ovr = 1;
         end else begin
            ovr = 0;
            q.push_back(m | ((st == 0) << 9) | ((bp & pen) << 10) | ((nb == 9) << 11));
         end
      end
      u_far.send(nb, m, pv, st, gb);
   endtask

   // Model queue holds data, ninth bit and the flags of each stored frame
   task automatic drain();
      repeat (2 * u_far.bclk) @(posedge i_clk);
      rd(3'h1, rv);
      check("overrun", {15'h0, rv[3]}, 16'(ovr));
      while (q.size() > 0) begin
         e = q.pop_front();
         rd(3'h1, rv);
         check("status", {8'h00, rv & 8'h94},
               16'(16'h80 | ((e >> 5) & 16'h10) | ((e >> 8) & 4)));
         if (e[11]) begin
            rd(3'h2, rv);
            check("ninth bit", {15'h0, rv[1]}, 16'(e[8]));
         end
         rd(3'h0, rv);
         check("data", {8'h00, rv}, 16'(e & 8'hFF));
      end
      rd(3'h1, rv);
      check("rx empty", {8'h00, rv & 8'h94}, 16'h0000);
   endtask

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         summarize();
      end
   end

   initial begin
      void'($urandom(46075));
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      wr(3'h6, 8'hFF);
      for (int a = 1; a < 8; a++) begin
         rd(3'(a), rv);
         check("reset value", {8'h00, rv}, {8'h00, rst_v[a]});
      end
      // Short stop then an immediate start, glitch on one data bit
      foreach (codes[i]) begin
         for (int s = 0; s < 2; s++) begin
            cfg(codes[i], $urandom % 2, $urandom % 2, s, 0);
            frame($urandom, 1, 0, $urandom % nb);
            frame($urandom, 1, 0, -1);
            drain();
         end
      end
      cfg(3, 1, 0, 0, 0);
      frame($urandom, 0, 0, -1);
      frame($urandom, 1, 1, -1);
      // Third frame finds the buffer full and is lost
      frame($urandom, 1, 0, -1);
      drain();
      // Low spike too short to survive the centre vote
      u_far.put(1'b0, 6, -1);
      u_far.put(1'b1, 40, -1);
      drain();
      cfg(7, 0, 0, 0, 1);
      frame(9'h0A5, 1, 0, -1);
      frame(9'h1C3, 1, 0, -1);
      frame(9'h05A, 1, 0, -1);
      drain();
      // Selected node drops the filter and takes data
      cfg(7, 0, 0, 1, 0);
      frame(9'h03C, 1, 0, -1);
      frame(9'h1F0, 1, 0, -1);
      drain();
      cfg(3, 0, 0, 0, 1);
      frame($urandom, 0, 0, -1);
      frame($urandom, 1, 0, -1);
      drain();
      cfg(1, 0, 0, 0, 1);
      d = $urandom;
      wr(3'h0, 8'(d));
      u_far.catch(6, tv, tok);
      check("tx data", {7'h00, tv}, 16'(d & 8'h3F));
      check("tx frame", {15'h0, tok}, 16'h0001);
      repeat (32) @(posedge i_clk);
      rd(3'h1, rv);
      check("tx done", {15'h0, rv[6]}, 16'h0001);
      wr(3'h1, 8'h01);
      rd(3'h1, rv);
      check("tx done kept", {15'h0, rv[6]}, 16'h0001);
      wr(3'h1, 8'h41);
      rd(3'h1, rv);
      check("tx done cleared", {15'h0, rv[6]}, 16'h0000);
      summarize();
   end
endmodule
